// >>> src/selcall_tone_code_decoder.sv
// selective-call tone decoder end: period classifier, code latch, strobe and clock output
//
// What this block does
// - classify input into fifteen channels, 4-bit code
// - latch qualified tone code and strobe
// - 33 ms without qualified tone gives no-tone
// - no-tone code is hex F
// - strobe on code change only, from the end of hex E on, at most one more held pending while busy
// - strobe 0.5 ms after data, 1 ms wide
// - hold low at change stretches strobe
// - after power-up reset show hex E, no strobe
// - power-up reset held high at least 1 ms
// - tone code shows hex F and strobe stays idle during power-up reset
// - one fixed toneset maps fifteen frequencies
// - 23.333 kHz clock is master divided by 24
// - tones last at least 20 ms
// - a gap gives no-tone once time from losing qualification to requalifying (16 ms) reaches 33 ms
`timescale 1ns/100ps
module selcall_tone_code_decoder #(
    parameter int QUAL_CYCLES         = selcall_pkg::QUAL_CYCLES,
    parameter int NOTONE_CYCLES       = selcall_pkg::NOTONE_CYCLES,
    parameter int STROBE_DELAY_CYCLES = selcall_pkg::STROBE_DELAY_CYCLES,
    parameter int STROBE_WIDTH_CYCLES = selcall_pkg::STROBE_WIDTH_CYCLES
) (
    // clock and reset
    input  wire logic    sys_clk_in,
    input  wire logic    reset_n_in,
    // limited audio
    input  wire logic    limited_tone_in,
    // link to receiver
    tone_link_if.device  link
);

    logic [2:0]           sync_a;
    logic [2:0]           sync_b;
    logic                 tone_last;
    logic                 tone_s;
    logic                 hold_n_s;
    logic                 pur_s;
    logic                 tone_rise;

    logic [27:0]          phase_acc;
    logic [27:0]          next_phase_acc;
    logic                 master_tick;
    logic                 next_master_tick;
    logic [3:0]           div_cnt;
    logic [3:0]           next_div_cnt;
    logic                 clk23;
    logic                 next_clk23;

    logic [11:0]          tone_period;
    logic [11:0]          next_tone_period;
    logic [3:0]           cand_code;
    logic [3:0]           next_cand_code;
    logic                 cand_valid;
    logic                 next_cand_valid;
    selcall_pkg::count_t  qual_cnt;
    selcall_pkg::count_t  next_qual_cnt;
    logic                 qual_done;
    logic                 next_qual_done;
    selcall_pkg::count_t  silence_cnt;
    selcall_pkg::count_t  next_silence_cnt;
    logic                 silence_expired;
    selcall_pkg::run_e    run_state;
    selcall_pkg::run_e    next_run_state;
    logic [3:0]           code;
    logic [3:0]           next_code;
    logic                 code_change;

    selcall_pkg::strobe_e sstate;
    selcall_pkg::strobe_e next_sstate;
    selcall_pkg::count_t  s_cnt;
    selcall_pkg::count_t  next_s_cnt;
    logic                 hold_latch;
    logic                 next_hold_latch;
    logic                 pending;
    logic                 next_pending;
    logic                 pend_hold;
    logic                 next_pend_hold;
    logic                 strobe;
    logic                 next_strobe;

    assign tone_s          = sync_b[0];
    assign hold_n_s        = sync_b[1];
    assign pur_s           = sync_b[2];
    assign tone_rise       = tone_s & ~tone_last;
    assign silence_expired = (silence_cnt == selcall_pkg::count_t'(NOTONE_CYCLES));

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_a    <= 3'h6;
            sync_b    <= 3'h6;
            tone_last <= 1'b0;
        end else begin
            sync_a    <= {link.power_up_reset, link.handshake_hold_n, limited_tone_in};
            sync_b    <= sync_a;
            tone_last <= sync_b[0];
        end
    end

    always_comb begin
        logic [4:0] hit;
        hit = selcall_pkg::classify_period(tone_period);
        // master tick and divide by 24
        next_phase_acc   = phase_acc + 28'(selcall_pkg::MASTER_HZ);
        next_master_tick = 1'b0;
        if (next_phase_acc >= 28'(selcall_pkg::SYS_CLK_HZ)) begin
            next_phase_acc   = next_phase_acc - 28'(selcall_pkg::SYS_CLK_HZ);
            next_master_tick = 1'b1;
        end
        next_div_cnt = div_cnt;
        next_clk23   = clk23;
        if (master_tick) begin
            if (div_cnt == 4'(selcall_pkg::MASTER_HALF - 1)) begin
                next_div_cnt = 4'h0;
                next_clk23   = ~clk23;
            end else begin
                next_div_cnt = div_cnt + 4'h1;
            end
        end
        next_tone_period = tone_period;
        if (tone_rise) begin
            next_tone_period = 12'h000;
        end else if (master_tick && tone_period != selcall_pkg::PERIOD_MAX) begin
            next_tone_period = tone_period + 12'h001;
        end
        next_cand_code  = cand_code;
        next_cand_valid = cand_valid;
        next_qual_cnt   = qual_cnt;
        next_qual_done  = qual_done;
        if (cand_valid && !qual_done) begin
            next_qual_cnt = qual_cnt + 24'h000001;
            if (qual_cnt == selcall_pkg::count_t'(QUAL_CYCLES - 1)) begin
                next_qual_done = 1'b1;
            end
        end
        if (tone_rise) begin
            if (hit[4] && !(cand_valid && hit[3:0] == cand_code)) begin
                next_cand_code  = hit[3:0];
                next_cand_valid = 1'b1;
                next_qual_cnt   = 24'h000000;
                next_qual_done  = 1'b0;
            end else if (!hit[4]) begin
                next_cand_valid = 1'b0;
                next_qual_done  = 1'b0;
            end
        end
        if (tone_period == selcall_pkg::PERIOD_MAX) begin
            next_cand_valid = 1'b0;
            next_qual_done  = 1'b0;
        end
        // silence timer, cleared by a held tone
        if (run_state == selcall_pkg::RUN_DECODE && qual_done) begin
            next_silence_cnt = 24'h000000;
        end else if (!silence_expired) begin
            next_silence_cnt = silence_cnt + 24'h000001;
        end else begin
            next_silence_cnt = silence_cnt;
        end
        next_run_state = run_state;
        next_code      = code;
        code_change    = 1'b0;
        case (run_state)
            selcall_pkg::RUN_RESET: begin
                next_run_state   = selcall_pkg::RUN_SHOW_E;
                next_code        = selcall_pkg::CODE_NO_DATA;
                next_silence_cnt = 24'h000000;
            end
            selcall_pkg::RUN_SHOW_E: begin
                // e stands exactly the no-tone time
                if (silence_cnt == selcall_pkg::count_t'(NOTONE_CYCLES - 1)) begin
                    next_run_state = selcall_pkg::RUN_DECODE;
                    next_code      = qual_done ? cand_code : selcall_pkg::CODE_NOTONE;
                    code_change    = (next_code != code);
                end
            end
            selcall_pkg::RUN_DECODE: begin
                if (qual_done) begin
                    next_code = cand_code;
                end else if (silence_expired) begin
                    next_code = selcall_pkg::CODE_NOTONE;
                end
                code_change = (next_code != code);
            end
            default: begin
                next_run_state = selcall_pkg::RUN_RESET;
            end
        endcase
        if (pur_s) begin
            next_run_state   = selcall_pkg::RUN_RESET;
            next_code        = selcall_pkg::CODE_NOTONE;
            next_cand_valid  = 1'b0;
            next_qual_done   = 1'b0;
            next_qual_cnt    = 24'h000000;
            next_silence_cnt = 24'h000000;
            code_change      = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_acc   <= 28'h0000000;
            master_tick <= 1'b0;
            div_cnt     <= 4'h0;
            clk23       <= 1'b0;
            tone_period <= 12'hfff;
            cand_code   <= 4'hf;
            cand_valid  <= 1'b0;
            qual_cnt    <= 24'h000000;
            qual_done   <= 1'b0;
            silence_cnt <= 24'h000000;
            run_state   <= selcall_pkg::RUN_RESET;
            code        <= 4'hf;
        end else begin
            phase_acc   <= next_phase_acc;
            master_tick <= next_master_tick;
            div_cnt     <= next_div_cnt;
            clk23       <= next_clk23;
            tone_period <= next_tone_period;
            cand_code   <= next_cand_code;
            cand_valid  <= next_cand_valid;
            qual_cnt    <= next_qual_cnt;
            qual_done   <= next_qual_done;
            silence_cnt <= next_silence_cnt;
            run_state   <= next_run_state;
            code        <= next_code;
        end
    end

    always_comb begin
        logic free;
        free            = 1'b0;
        next_sstate     = sstate;
        next_s_cnt      = s_cnt;
        next_hold_latch = hold_latch;
        next_pending    = pending;
        next_pend_hold  = pend_hold;
        case (sstate)
            selcall_pkg::ST_IDLE: begin
                free = 1'b1;
            end
            selcall_pkg::ST_DELAY: begin
                next_s_cnt = s_cnt + 24'h000001;
                if (s_cnt == selcall_pkg::count_t'(STROBE_DELAY_CYCLES - 1)) begin
                    next_sstate = selcall_pkg::ST_PULSE;
                    next_s_cnt  = 24'h000000;
                end
            end
            selcall_pkg::ST_PULSE: begin
                next_s_cnt = s_cnt + 24'h000001;
                if (s_cnt == selcall_pkg::count_t'(STROBE_WIDTH_CYCLES - 1)) begin
                    if (hold_latch && !hold_n_s) begin
                        next_sstate = selcall_pkg::ST_HOLD;
                    end else begin
                        free = 1'b1;
                    end
                end
            end
            selcall_pkg::ST_HOLD: begin
                if (hold_n_s) begin
                    free = 1'b1;
                end
            end
            default: begin
                free = 1'b1;
            end
        endcase
        // one strobe per change, at most one more change held pending while busy
        if (free) begin
            next_sstate = selcall_pkg::ST_IDLE;
            if (code_change || pending) begin
                next_sstate     = selcall_pkg::ST_DELAY;
                next_s_cnt      = 24'h000000;
                next_hold_latch = code_change ? ~hold_n_s : pend_hold;
                next_pending    = 1'b0;
            end
        end else if (code_change) begin
            next_pending   = 1'b1;
            next_pend_hold = ~hold_n_s;
        end
        if (pur_s) begin
            next_sstate  = selcall_pkg::ST_IDLE;
            next_pending = 1'b0;
        end
        next_strobe = (next_sstate == selcall_pkg::ST_PULSE) ||
                      (next_sstate == selcall_pkg::ST_HOLD);
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sstate     <= selcall_pkg::ST_IDLE;
            s_cnt      <= 24'h000000;
            hold_latch <= 1'b0;
            pending    <= 1'b0;
            pend_hold  <= 1'b0;
            strobe     <= 1'b0;
        end else begin
            sstate     <= next_sstate;
            s_cnt      <= next_s_cnt;
            hold_latch <= next_hold_latch;
            pending    <= next_pending;
            pend_hold  <= next_pend_hold;
            strobe     <= next_strobe;
        end
    end

    assign link.tone_code   = code;
    assign link.code_strobe = strobe;
    assign link.clock_23k   = clk23;

endmodule

// >>> src/selcall_pkg.sv
// shared constants, types and the tone table for the selcall decoder and its receiver
package selcall_pkg;

    // clocks
    localparam int SYS_CLK_HZ     = 100_000_000;
    localparam int CLK_MHZ        = SYS_CLK_HZ / 1_000_000;
    localparam int CLK_PER_MS     = SYS_CLK_HZ / 1000;
    localparam int MASTER_HZ      = 560_000;
    localparam int MASTER_DIV     = 24;
    localparam int MASTER_HALF    = MASTER_DIV / 2;
    localparam int PHASE_W        = 28;

    // codes
    localparam int         CODE_W       = 4;
    localparam int         NUM_TONES    = 15;
    localparam logic [3:0] CODE_NOTONE  = 4'hf;
    localparam logic [3:0] CODE_NO_DATA = 4'he;

    // period measurement in master clock cycles
    localparam int          PERIOD_W   = 12;
    localparam logic [11:0] PERIOD_MAX = 12'hfff;
    localparam int          TOL_PCT    = 2;
    localparam int          TONE_HZ [0:14] = '{1981, 1124, 1197, 1275, 1358, 1446, 1540, 1640,
                                              1747, 1860, 2400, 930, 2247, 991, 2110};

    // times in their own units
    localparam int QUAL_TIME_MS     = 16;
    localparam int NOTONE_TIME_MS   = 33;
    localparam int STROBE_DELAY_US  = 500;
    localparam int STROBE_WIDTH_US  = 1000;
    localparam int PUR_TIME_US      = 1000;

    // times in system clock cycles
    localparam int QUAL_CYCLES         = QUAL_TIME_MS * CLK_PER_MS;
    localparam int NOTONE_CYCLES       = NOTONE_TIME_MS * CLK_PER_MS;
    localparam int STROBE_DELAY_CYCLES = STROBE_DELAY_US * CLK_MHZ;
    localparam int STROBE_WIDTH_CYCLES = STROBE_WIDTH_US * CLK_MHZ;
    localparam int PUR_CYCLES          = PUR_TIME_US * CLK_MHZ;

    // receiver buffering
    localparam int FIFO_DEPTH = 16;

    typedef logic [23:0] count_t;

    typedef enum logic [1:0] {
        RUN_RESET  = 2'b00,
        RUN_SHOW_E = 2'b01,
        RUN_DECODE = 2'b11
    } run_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_PULSE = 2'b11,
        ST_HOLD  = 2'b10
    } strobe_e;

    function automatic logic [11:0] period_lo(input int idx);
        return 12'((MASTER_HZ * (100 - TOL_PCT)) / (100 * TONE_HZ[idx]));
    endfunction

    function automatic logic [11:0] period_hi(input int idx);
        return 12'((MASTER_HZ * (100 + TOL_PCT)) / (100 * TONE_HZ[idx]));
    endfunction

    // returns {hit, code} for a measured period
    function automatic logic [4:0] classify_period(input logic [11:0] p);
        logic [4:0] r;
        r = {1'b0, CODE_NOTONE};
        for (int i = 0; i < NUM_TONES; i++) begin
            if (p >= period_lo(i) && p <= period_hi(i)) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

endpackage

// >>> src/tone_link_if.sv
// pin-level link between the tone decoder and its receiving logic
`timescale 1ns/100ps
interface tone_link_if;
    logic [3:0] tone_code;
    logic       code_strobe;
    logic       clock_23k;
    logic       handshake_hold_n;
    logic       power_up_reset;

    modport device (
        output tone_code,
        output code_strobe,
        output clock_23k,
        input  handshake_hold_n,
        input  power_up_reset
    );

    modport host (
        input  tone_code,
        input  code_strobe,
        output handshake_hold_n,
        output power_up_reset
    );
endinterface

// >>> src/code_receiver.sv
// receiving end: power-up reset source, strobe capture, code fifo and hold handshake
`timescale 1ns/100ps
module code_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_out  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_out = (wr_ptr != rd_ptr);
    assign out_data_out  = mem[rd_ptr[AW-1:0]];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
    end

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
endmodule

module code_receiver #(
    parameter int PUR_CYCLES = selcall_pkg::PUR_CYCLES,
    parameter int FIFO_DEPTH = selcall_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic    sys_clk_in,
    input  wire logic    reset_n_in,
    // link to decoder
    tone_link_if.host    link,
    // received codes
    output logic [3:0]   code_out,
    output logic         code_valid_out,
    input  wire logic    code_ready_in
);
    logic [4:0]          sync_a;
    logic [4:0]          sync_b;
    logic                strobe_last;
    logic                strobe_rise;
    selcall_pkg::count_t pur_cnt;
    selcall_pkg::count_t next_pur_cnt;
    logic                pur;
    logic                next_pur;
    logic                pending;
    logic                next_pending;
    logic [3:0]          pend_code;
    logic [3:0]          next_pend_code;
    logic                hold_n;
    logic                next_hold_n;
    logic                fifo_in_ready;
    logic                fifo_valid;
    logic [3:0]          fifo_data;
    logic                fifo_pop;
    logic [3:0]          next_code_out;
    logic                next_code_valid;

    assign strobe_rise = sync_b[4] & ~strobe_last;
    assign fifo_pop    = ~code_valid_out | code_ready_in;

    always_comb begin
        // power-up reset held for its minimum
        next_pur_cnt = pur_cnt;
        next_pur     = pur;
        if (pur) begin
            next_pur_cnt = pur_cnt + 24'h000001;
            if (pur_cnt == selcall_pkg::count_t'(PUR_CYCLES - 1)) begin
                next_pur = 1'b0;
            end
        end
        next_pend_code = pend_code;
        next_pending   = pending;
        if (pending && fifo_in_ready) begin
            next_pending = 1'b0;
        end
        if (strobe_rise) begin
            next_pending   = 1'b1;
            next_pend_code = sync_b[3:0];
        end
        // hold low while a code waits
        next_hold_n     = ~(next_pending | ~fifo_in_ready);
        next_code_out   = code_out;
        next_code_valid = code_valid_out & ~code_ready_in;
        if (fifo_pop && fifo_valid) begin
            next_code_out   = fifo_data;
            next_code_valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_a         <= 5'h0f;
            sync_b         <= 5'h0f;
            strobe_last    <= 1'b0;
            pur_cnt        <= 24'h000000;
            pur            <= 1'b1;
            pending        <= 1'b0;
            pend_code      <= 4'hf;
            hold_n         <= 1'b1;
            code_out       <= 4'hf;
            code_valid_out <= 1'b0;
        end else begin
            sync_a         <= {link.code_strobe, link.tone_code};
            sync_b         <= sync_a;
            strobe_last    <= sync_b[4];
            pur_cnt        <= next_pur_cnt;
            pur            <= next_pur;
            pending        <= next_pending;
            pend_code      <= next_pend_code;
            hold_n         <= next_hold_n;
            code_out       <= next_code_out;
            code_valid_out <= next_code_valid;
        end
    end

    code_fifo #(
        .WIDTH (4),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (pending),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (pend_code),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_data)
    );

    assign link.handshake_hold_n = hold_n;
    assign link.power_up_reset   = pur;

endmodule

// >>> verification/tone_link_props.sv
// concurrent checks on the decoder to receiver link
`timescale 1ns/100ps
module tone_link_props #(
    parameter int D1  = 20,
    parameter int WID = 40,
    parameter int PUR = 50,
    parameter int NT  = 800
) (
    // clock and reset
    input wire logic       sys_clk_in,
    input wire logic       reset_n_in,
    // link signals
    input wire logic [3:0] tone_code,
    input wire logic       code_strobe,
    input wire logic       clock_23k,
    input wire logic       handshake_hold_n,
    input wire logic       power_up_reset
);
    logic [23:0] hi_cnt, pur_cnt, since_pur, clk_cnt;
    logic        clk_seen;
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hi_cnt    <= '0;
            pur_cnt   <= '0;
            since_pur <= '0;
            clk_cnt   <= '0;
            clk_seen  <= 1'b0;
        end else begin
            clk_seen  <= clk_seen | $changed(clock_23k);
            hi_cnt    <= code_strobe ? hi_cnt + 24'h1 : '0;
            pur_cnt   <= power_up_reset ? pur_cnt + 24'h1 : '0;
            since_pur <= power_up_reset ? '0 : since_pur + 24'h1;
            clk_cnt   <= $changed(clock_23k) ? '0 : clk_cnt + 24'h1;
        end
    end
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    sequence s_new_code;
        $changed(tone_code) && tone_code != 4'he && !power_up_reset && !code_strobe;
    endsequence
    sequence s_late_rise;
        ##D1 $rose(code_strobe);
    endsequence
    chk_strobe_delay: assert property (s_new_code |-> s_late_rise)
        else $error("strobe off delay");
    chk_width_min: assert property (code_strobe && hi_cnt < WID - 1 |=> code_strobe)
        else $error("strobe short");
    chk_width_end: assert property (code_strobe && hi_cnt == WID - 1
        && $past(handshake_hold_n, 2) && $past(handshake_hold_n, 3) |=> !code_strobe)
        else $error("strobe long");
    chk_pur_quiet: assert property (power_up_reset && $past(power_up_reset, 3)
        |-> !$rose(code_strobe))
        else $error("strobe in reset");
    chk_e_shown: assert property ($fell(power_up_reset) |-> ##[2:5] tone_code == 4'he)
        else $error("no e code");
    chk_e_stands: assert property (since_pur > 5 && since_pur <= NT |-> tone_code == 4'he)
        else $error("e code left");
    chk_notone_code: assert property (since_pur == NT + 8 |-> tone_code == 4'hf)
        else $error("no f code");
    chk_clk_half: assert property ($changed(clock_23k) && clk_seen |-> clk_cnt inside {[2141:2143]})
        else $error("clock half period");
    chk_hold_ack: assert property ($rose(code_strobe) |-> ##[2:5] !handshake_hold_n)
        else $error("no hold ack");
    chk_pur_width: assert property ($fell(power_up_reset) |-> pur_cnt >= PUR - 1)
        else $error("reset short");
endmodule

// >>> verification/selcall_tone_code_decoder_tb.sv
// bench for the tone decoder, its receiver and the code fifo
`timescale 1ns/100ps
module selcall_tone_code_decoder_tb;
    logic       sys_clk_in = 1'b0;
    logic       reset_n_in = 1'b0;
    logic       limited_tone_in = 1'b0;
    logic       code_ready_in = 1'b0;
    logic [3:0] code_out;
    logic       code_valid_out;
    logic [3:0] got[$];
    logic [3:0] exp_codes[3] = '{4'hf, 4'ha, 4'hf};
    int         errors = 0;
    int         checks = 0;
    int         cycles = 0;
    int         n;
    always #5 sys_clk_in = ~sys_clk_in;
    tone_link_if tone_link_if_i ();
    wire [3:0] code_pin = tone_link_if_i.tone_code;
    selcall_tone_code_decoder #(.QUAL_CYCLES(400), .NOTONE_CYCLES(800),
        .STROBE_DELAY_CYCLES(20), .STROBE_WIDTH_CYCLES(40)) selcall_tone_code_decoder_i (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .limited_tone_in(limited_tone_in), .link(tone_link_if_i.device));
    code_receiver #(.PUR_CYCLES(50)) code_receiver_i (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .link(tone_link_if_i.host),
        .code_out(code_out), .code_valid_out(code_valid_out), .code_ready_in(code_ready_in));
    tone_link_props tone_link_props_i (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .tone_code(code_pin),
        .code_strobe(tone_link_if_i.code_strobe), .clock_23k(tone_link_if_i.clock_23k),
        .handshake_hold_n(tone_link_if_i.handshake_hold_n),
        .power_up_reset(tone_link_if_i.power_up_reset));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // counts cycles while the code pin or strobe matches c as asked
    task automatic span(input logic sel, input logic [3:0] c, input logic same);
        n = 0;
        while (((sel ? {3'h0, tone_link_if_i.code_strobe} : code_pin) === c) === same) begin
            @(negedge sys_clk_in);
            n++;
        end
    endtask
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (code_valid_out === 1'b1 && code_ready_in === 1'b1) begin
            got.push_back(code_out);
        end
        if (cycles == 60000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        repeat (10) @(negedge sys_clk_in);
        check(code_pin, 4'hf);
        span(1'b0, 4'he, 1'b0);
        span(1'b0, 4'he, 1'b1);
        check(n, 800);
        check(code_pin, 4'hf);
        span(1'b1, 4'h1, 1'b0);
        check(n, 20);
        span(1'b1, 4'h1, 1'b1);
        check(n, 40);
        check({code_valid_out, code_out}, 5'h1f);
        check(tone_link_if_i.handshake_hold_n, 1'b1);
        @(posedge sys_clk_in);
        code_ready_in   <= 1'b1;
        limited_tone_in <= 1'b1;
        repeat (2) @(negedge sys_clk_in);
        check(code_valid_out, 1'b0);
        check(got.size(), 1);
        repeat (20833) @(posedge sys_clk_in);
        limited_tone_in <= 1'b0;
        repeat (20834) @(posedge sys_clk_in);
        limited_tone_in <= 1'b1;
        span(1'b0, 4'ha, 1'b0);
        check(n >= 400 && n <= 700, 1'b1);
        repeat (100) @(posedge sys_clk_in);
        limited_tone_in <= 1'b0;
        repeat (100) @(posedge sys_clk_in);
        limited_tone_in <= 1'b1;
        span(1'b0, 4'hf, 1'b0);
        check(n >= 780 && n <= 1100, 1'b1);
        repeat (100) @(negedge sys_clk_in);
        check(got.size(), 3);
        foreach (exp_codes[i]) check(got[i], exp_codes[i]);
        tally_and_finish();
    end
endmodule
